// file: hdl/spfc_top.sv
// Serial port, output ports, timebase and general-purpose counter of a tuner synthesizer.
// Assumes aclk at 25 MHz, an AXI4-Lite master, and the link clock from the controller.
//
// Summary of operation
// - Serial clock times every bit in and out
// - Shift 28 bits out on open-drain data line
// - Latch seven port bits, drive them inverted
// - Timebase select puts 8 Hz on port zero
// - Input port levels go into output word
// - Source select one routes high-speed input, frequency
// - High-speed input divided by eight, 20-bit count
// - Gate bit picks 12 ms or 24 ms
// - Count shifts out most significant bit first
// - Source select zero routes low-speed input
// - Low-speed frequency counts direct, same gate
// - Low-speed function zero measures period
// - Period span is one or two cycles
`timescale 1ns/1ps
`include "spfc_defines.svh"
module spfc_top #(
  parameter int GATE_SHORT_CYC = `SPFC_GATE_SHORT_CYC,
  parameter int GATE_LONG_CYC = `SPFC_GATE_LONG_CYC,
  parameter int TB_HALF_CYC = `SPFC_TB_HALF_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic serial_clock_line,
  input wire logic chip_enable,
  input wire logic serial_data_in,
  output logic serial_data_out_oe,
  output logic [6:0] port_out,
  output logic [6:0] port_out_oe,
  input wire logic port_in_zero,
  input wire logic port_in_one,
  input wire logic high_speed_count_input,
  input wire logic low_speed_count_input
);
  import spfc_pkg::*;

  localparam int GW = 20;
  localparam int TW = 22;

  if (GATE_SHORT_CYC < 2 || GATE_LONG_CYC < 2 || GATE_LONG_CYC >= 2 ** GW) begin : g_bad_gate
    $error("gate lengths out of range for the gate counter");
  end
  if (TB_HALF_CYC < 1 || TB_HALF_CYC >= 2 ** TW) begin : g_bad_tb
    $error("timebase half period out of range");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    spfc_meas_t st;
    logic [GW-1:0] gate;
    logic [19:0] cnt;
    logic [2:0] pre;
    logic periods;
    logic [19:0] result;
    logic done;
    logic edge_q;
    logic [TW-1:0] tb_cnt;
    logic tb_lvl;
    spfc_ctrl_t ctrl;
    logic [`SPFC_CW_BITS-1:0] cw;
    logic full_q;
    logic [`SPFC_TX_BITS-1:0] tx_word;
    logic meas_en;
    logic [6:0] port_out;
    logic [6:0] port_oe;
    logic awready;
    logic aw_have;
    logic [7:0] aw_addr;
    logic wready;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } spfc_core_t;

  spfc_core_t q;
  spfc_core_t next_q;

  logic [`SPFC_CW_BITS-1:0] rx_word;
  logic rx_full;
  logic [5:0] pins_s;
  logic ce_s;
  logic full_s;
  logic in0_s;
  logic in1_s;
  logic hs_s;
  logic ls_s;
  logic sel_in;
  logic rise;
  logic cw_evt;
  logic period_mode;
  logic [GW-1:0] gate_len;
  logic [6:0] port_lvl;

  // ****************************************
  // Link and pin crossings
  // ****************************************
  spfc_serial_link u_link (
    .serial_clock_line(serial_clock_line),
    .chip_enable(chip_enable),
    .serial_data_in(serial_data_in),
    .tx_word(q.tx_word),
    .rx_word(rx_word),
    .rx_full(rx_full),
    .serial_data_out_oe(serial_data_out_oe)
  );

  spfc_sync #(.W(6)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({chip_enable, rx_full, port_in_zero, port_in_one, high_speed_count_input, low_speed_count_input}),
    .sync_out(pins_s)
  );

  assign {ce_s, full_s, in0_s, in1_s, hs_s, ls_s} = pins_s;

  // High-speed input is only sampled, so it must stay well below half of aclk
  assign sel_in = q.ctrl.counter_source_select ? hs_s : ls_s;
  assign rise = sel_in & ~q.edge_q;
  assign cw_evt = full_s & ~q.full_q;
  assign period_mode = ~q.ctrl.counter_source_select & ~q.ctrl.low_input_function_select;
  assign gate_len = q.ctrl.gate_time_select ? GW'(GATE_LONG_CYC) : GW'(GATE_SHORT_CYC);

  always_comb begin
    next_q = q;
    next_q.edge_q = sel_in;
    next_q.full_q = full_s;

    // ****************************************
    // Control word capture
    // ****************************************
    // The word is copied only once all 36 bits have arrived
    if (cw_evt) begin
      next_q.cw = rx_word;
      next_q.ctrl.port_bit = rx_word[`SPFC_CW_PORT_LSB +: 7];
      next_q.ctrl.timebase_output_select = rx_word[`SPFC_CW_TB];
      next_q.ctrl.counter_source_select = rx_word[`SPFC_CW_SC];
      next_q.ctrl.low_input_function_select = rx_word[`SPFC_CW_SF];
      next_q.ctrl.gate_time_select = rx_word[`SPFC_CW_GT];
    end

    // ****************************************
    // Timebase and output ports
    // ****************************************
    if (q.tb_cnt == TW'(TB_HALF_CYC - 1)) begin
      next_q.tb_cnt = '0;
      next_q.tb_lvl = ~q.tb_lvl;
    end else begin
      next_q.tb_cnt = q.tb_cnt + TW'(1);
    end
    port_lvl = ~q.ctrl.port_bit;
    if (q.ctrl.timebase_output_select) begin
      port_lvl[0] = q.tb_lvl;
    end
    next_q.port_out = port_lvl;
    next_q.port_oe = ~(`SPFC_OD_MASK & port_lvl);

    // ****************************************
    // Result word, refreshed only between frames
    // ****************************************
    if (!ce_s) begin
      next_q.tx_word = {q.result, in1_s, in0_s, q.done, 5'h00};
    end

    // ****************************************
    // Measurement
    // ****************************************
    case (q.st)
      SPFC_IDLE: begin
        if (q.meas_en && !cw_evt) begin
          next_q.cnt = '0;
          next_q.pre = '0;
          next_q.gate = '0;
          next_q.periods = 1'b0;
          next_q.st = period_mode ? SPFC_ARM : SPFC_RUN;
        end
      end
      SPFC_ARM: begin
        if (rise) begin
          next_q.st = SPFC_RUN;
        end
      end
      SPFC_RUN: begin
        if (period_mode) begin
          if (q.cnt != 20'hFFFFF) begin
            next_q.cnt = q.cnt + 20'h00001;
          end
          if (rise) begin
            next_q.periods = 1'b1;
            if (q.periods == q.ctrl.gate_time_select) begin
              next_q.result = q.cnt;
              next_q.st = SPFC_HOLD;
            end
          end
        end else begin
          next_q.gate = q.gate + GW'(1);
          if (rise) begin
            next_q.pre = q.pre + 3'h1;
            if ((!q.ctrl.counter_source_select || q.pre == 3'h7) && q.cnt != 20'hFFFFF) begin
              next_q.cnt = q.cnt + 20'h00001;
            end
          end
          if (q.gate == gate_len - GW'(1)) begin
            next_q.result = next_q.cnt;
            next_q.st = SPFC_HOLD;
          end
        end
      end
      SPFC_HOLD: begin
        next_q.done = 1'b1;
        next_q.st = SPFC_IDLE;
      end
      default: begin
        next_q.st = SPFC_IDLE;
      end
    endcase
    // A new control word restarts the measurement in the new mode
    if (cw_evt && q.st != SPFC_HOLD) begin
      next_q.st = SPFC_IDLE;
    end

    // ****************************************
    // AXI4-Lite write
    // ****************************************
    if (awvalid && q.awready) begin
      next_q.aw_have = 1'b1;
      next_q.aw_addr = awaddr;
      next_q.awready = 1'b0;
    end
    if (wvalid && q.wready) begin
      next_q.w_have = 1'b1;
      next_q.w_data = wdata;
      next_q.w_strb = wstrb;
      next_q.wready = 1'b0;
    end
    if (q.aw_have && q.w_have && !q.bvalid) begin
      next_q.aw_have = 1'b0;
      next_q.w_have = 1'b0;
      next_q.bvalid = 1'b1;
      if (q.aw_addr == `SPFC_ADDR_CTRL) begin
        next_q.bresp = `SPFC_RESP_OKAY;
        if (q.w_strb[0]) begin
          next_q.meas_en = q.w_data[`SPFC_CTRL_MEAS_EN];
        end
      end else if (q.aw_addr == `SPFC_ADDR_STATUS || q.aw_addr == `SPFC_ADDR_WORD_LO
                   || q.aw_addr == `SPFC_ADDR_WORD_HI) begin
        next_q.bresp = `SPFC_RESP_OKAY;
      end else begin
        next_q.bresp = `SPFC_RESP_SLVERR;
      end
    end
    if (q.bvalid && bready) begin
      next_q.bvalid = 1'b0;
      next_q.awready = 1'b1;
      next_q.wready = 1'b1;
    end

    // ****************************************
    // AXI4-Lite read
    // ****************************************
    if (arvalid && q.arready) begin
      next_q.arready = 1'b0;
      next_q.rvalid = 1'b1;
      next_q.rresp = `SPFC_RESP_OKAY;
      if (araddr == `SPFC_ADDR_CTRL) begin
        next_q.rdata = {31'h00000000, q.meas_en};
      end else if (araddr == `SPFC_ADDR_STATUS) begin
        next_q.rdata = {8'h00, q.st != SPFC_IDLE, in1_s, in0_s, q.done, q.result};
      end else if (araddr == `SPFC_ADDR_WORD_LO) begin
        next_q.rdata = q.cw[31:0];
      end else if (araddr == `SPFC_ADDR_WORD_HI) begin
        next_q.rdata = {28'h0000000, q.cw[`SPFC_CW_BITS-1:32]};
      end else begin
        next_q.rdata = 32'h00000000;
        next_q.rresp = `SPFC_RESP_SLVERR;
      end
    end
    if (q.rvalid && rready) begin
      next_q.rvalid = 1'b0;
      next_q.arready = 1'b1;
    end
  end

  // Ports come out of reset at a defined level instead of floating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= SPFC_IDLE;
      q.meas_en <= `SPFC_CTRL_RESET;
      q.port_out <= 7'h7F;
      q.port_oe <= 7'h06;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign port_out = q.port_out;
  assign port_out_oe = q.port_oe;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_freq_gate_end;
    q.st == SPFC_RUN && !period_mode && q.gate == gate_len - GW'(1) && !cw_evt;
  endsequence

  sequence s_period_end;
    q.st == SPFC_RUN && period_mode && rise && q.periods == q.ctrl.gate_time_select && !cw_evt;
  endsequence

  chk_port_invert: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> port_out[6:1] == ~$past(q.ctrl.port_bit[6:1]))
    else $error("output ports are not the inverted latched bits");

  chk_tb_on_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    q.ctrl.timebase_output_select |=> port_out[0] == $past(q.tb_lvl))
    else $error("port zero does not carry the timebase");

  chk_gate_window: assert property (@(posedge aclk) disable iff (!aresetn)
    s_freq_gate_end |=> q.st == SPFC_HOLD ##1 q.done && q.st == SPFC_IDLE)
    else $error("frequency gate did not close on time");

  chk_gate_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == SPFC_RUN && !period_mode) |-> q.gate < gate_len)
    else $error("gate counter ran past the window");

  chk_prescale: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == SPFC_RUN && q.ctrl.counter_source_select && rise && q.pre != 3'h7 && !cw_evt)
    |=> q.cnt == $past(q.cnt))
    else $error("high-speed count skipped the divide by eight");

  chk_direct_count: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == SPFC_RUN && !q.ctrl.counter_source_select && q.ctrl.low_input_function_select
     && rise && q.cnt != 20'hFFFFF && !cw_evt) |=> q.cnt == $past(q.cnt) + 20'h00001)
    else $error("low-speed frequency edge not counted");

  chk_period_span: assert property (@(posedge aclk) disable iff (!aresetn)
    s_period_end |=> q.st == SPFC_HOLD && q.result == $past(q.cnt))
    else $error("period span did not end on the right edge");

  chk_clear_start: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == SPFC_IDLE && q.meas_en && !cw_evt) |=> q.cnt == 20'h00000)
    else $error("counter not cleared at measurement start");

  chk_result_word: assert property (@(posedge aclk) disable iff (!aresetn)
    !ce_s |=> q.tx_word[`SPFC_TX_BITS-1:`SPFC_TX_RESULT_LSB] == $past(q.result)
    && q.tx_word[6] == $past(in0_s) && q.tx_word[7] == $past(in1_s))
    else $error("result word does not carry count and input ports");
endmodule : spfc_top

// file: hdl/spfc_defines.svh
// Constants of the serial port, output port and frequency counter block.
// Assumes inclusion by bare name from files under hdl/.
`ifndef SPFC_DEFINES_SVH
`define SPFC_DEFINES_SVH

// ****************************************
// Serial words
// ****************************************
`define SPFC_CW_BITS 36
`define SPFC_TX_BITS 28
`define SPFC_CW_PORT_LSB 0
`define SPFC_CW_TB 7
`define SPFC_CW_SC 8
`define SPFC_CW_SF 9
`define SPFC_CW_GT 10
`define SPFC_TX_RESULT_LSB 8

// ****************************************
// Register offsets and reset values
// ****************************************
`define SPFC_ADDR_CTRL 8'h00
`define SPFC_ADDR_STATUS 8'h04
`define SPFC_ADDR_WORD_LO 8'h08
`define SPFC_ADDR_WORD_HI 8'h0C
`define SPFC_CTRL_MEAS_EN 0
`define SPFC_CTRL_RESET 1'h1
`define SPFC_RESP_OKAY 2'h0
`define SPFC_RESP_SLVERR 2'h2
`define SPFC_OD_MASK 7'h79

// ****************************************
// Timing
// ****************************************
`define SPFC_CLK_HZ 25000000
`define SPFC_GATE_SHORT_MS 12
`define SPFC_GATE_LONG_MS 24
`define SPFC_TB_HZ 8
`define SPFC_GATE_SHORT_CYC (`SPFC_CLK_HZ / 1000 * `SPFC_GATE_SHORT_MS)
`define SPFC_GATE_LONG_CYC (`SPFC_CLK_HZ / 1000 * `SPFC_GATE_LONG_MS)
`define SPFC_TB_HALF_CYC (`SPFC_CLK_HZ / (2 * `SPFC_TB_HZ))

`endif

// file: hdl/spfc_pkg.sv
// Types shared by the serial port and frequency counter block.
// Assumes nothing of its surroundings.
package spfc_pkg;

  // ****************************************
  // Control word fields
  // ****************************************
  typedef struct packed {
    logic gate_time_select;
    logic low_input_function_select;
    logic counter_source_select;
    logic timebase_output_select;
    logic [6:0] port_bit;
  } spfc_ctrl_t;

  // ****************************************
  // Measurement sequence
  // ****************************************
  typedef enum logic [1:0] {
    SPFC_IDLE,
    SPFC_ARM,
    SPFC_RUN,
    SPFC_HOLD
  } spfc_meas_t;

endpackage : spfc_pkg

// file: hdl/spfc_sync.sv
// Two flip-flop synchroniser for a group of pin levels.
// Assumes the inputs come from another clock domain or from pins.
`timescale 1ns/1ps
module spfc_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } spfc_sync_t;

  spfc_sync_t q;
  spfc_sync_t next_q;

  if (W < 1) begin : g_bad_width
    $error("spfc_sync width must be at least one");
  end

  always_comb begin
    next_q.s1 = async_in;
    next_q.s2 = q.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign sync_out = q.s2;
endmodule : spfc_sync

// file: hdl/spfc_serial_link.sv
// Link end of the three-wire port: shifts the control word in, the result word out.
// Assumes the controller keeps chip_enable high for a whole transfer.
`timescale 1ns/1ps
`include "spfc_defines.svh"
module spfc_serial_link
  import spfc_pkg::*;
(
  input wire logic serial_clock_line,
  input wire logic chip_enable,
  input wire logic serial_data_in,
  input wire logic [`SPFC_TX_BITS-1:0] tx_word,
  output logic [`SPFC_CW_BITS-1:0] rx_word,
  output logic rx_full,
  output logic serial_data_out_oe
);
  typedef struct packed {
    logic [5:0] cnt;
    logic full;
    logic [`SPFC_TX_BITS-1:0] tx_sh;
    logic oe;
  } spfc_link_t;

  spfc_link_t q;
  spfc_link_t next_q;
  logic [`SPFC_CW_BITS-1:0] rx_sh;
  // Not defined until the first frame, since the link has no reset of its own
  logic rx_done;

  always_comb begin
    next_q = q;
    if (q.cnt == 6'h00) begin
      next_q.oe = ~tx_word[`SPFC_TX_BITS-1];
      next_q.tx_sh = {tx_word[`SPFC_TX_BITS-2:0], 1'b0};
    end else if (q.cnt < 6'(`SPFC_TX_BITS)) begin
      next_q.oe = ~q.tx_sh[`SPFC_TX_BITS-1];
      next_q.tx_sh = {q.tx_sh[`SPFC_TX_BITS-2:0], 1'b0};
    end else begin
      next_q.oe = 1'b0;
    end
    if (q.cnt < 6'(`SPFC_CW_BITS)) begin
      next_q.cnt = q.cnt + 6'h01;
    end
    next_q.full = (next_q.cnt == 6'(`SPFC_CW_BITS));
  end

  // Dropping chip_enable ends the frame at once, since the clock may stop with it
  always_ff @(posedge serial_clock_line or negedge chip_enable) begin
    if (!chip_enable) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Word and done flag outlive chip_enable low, so the core can copy them after the frame
  // The flag only falls at the first edge of the next frame, long enough for the synchroniser
  always_ff @(posedge serial_clock_line) begin
    if (chip_enable && q.cnt < 6'(`SPFC_CW_BITS)) begin
      rx_sh <= {rx_sh[`SPFC_CW_BITS-2:0], serial_data_in};
      rx_done <= next_q.full;
    end
  end

  assign rx_word = rx_sh;
  assign rx_full = rx_done;
  assign serial_data_out_oe = q.oe;

  // ****************************************
  // Checks
  // ****************************************
  chk_first_out_bit: assert property (@(posedge serial_clock_line) disable iff (!chip_enable)
    (q.cnt == 6'h00) |=> (serial_data_out_oe == ~$past(tx_word[`SPFC_TX_BITS-1])))
    else $error("first output bit is not the word MSB");
endmodule : spfc_serial_link

// file: bench/spfc_ctrl_model.sv
// Controller model: drives the three-wire port and reads the result word.
// Assumes the device data line is open drain with a pull-up.
`timescale 1ns/1ps
module spfc_ctrl_model (
  output logic serial_clock_line,
  output logic chip_enable,
  output logic serial_data_in,
  input wire logic serial_data_out_oe
);
  // Pull-up: released line reads high
  wire logic sdo = !serial_data_out_oe;
  initial begin
    serial_clock_line = 1'b0;
    chip_enable = 1'b0;
    serial_data_in = 1'b0;
  end
  // Full 36-bit frame; clock stands still outside frames
  task automatic xfer(input logic [35:0] w, output logic [27:0] r);
    r = '0;
    chip_enable = 1'b1;
    // Give the core a few cycles to freeze the result word before the first edge
    #200;
    for (int i = 0; i < 36; i++) begin
      serial_data_in = w[35-i];
      #15 serial_clock_line = 1'b1;
      #15 serial_clock_line = 1'b0;
      if (i < 28) r[27-i] = sdo;
    end
    #15 chip_enable = 1'b0;
    // Data line is no longer valid once the frame ends
    serial_data_in = !serial_data_in;
    #400;
  endtask : xfer
endmodule : spfc_ctrl_model

// file: bench/tb.sv
// Self-checking bench for the serial port, output port and counter block.
// Assumes spfc_ctrl_model stands in for the controller on the link.
`timescale 1ns/1ps
`include "spfc_defines.svh"
module tb;
  import spfc_pkg::*;
  // Short gates keep the run brief
  localparam int GS = 20;
  localparam int GL = 40;
  logic aclk, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic serial_clock_line, chip_enable, serial_data_in, serial_data_out_oe;
  logic [1:0] bresp, rresp;
  logic [6:0] port_out, port_out_oe;
  logic port_in_zero = 1'b0, port_in_one = 1'b0;
  logic high_speed_count_input = 1'b0, low_speed_count_input = 1'b0;
  int hs_half = 0, ls_half = 0, cyc = 0, fail_count = 0, comparisons = 0;

  spfc_top #(.GATE_SHORT_CYC(GS), .GATE_LONG_CYC(GL), .TB_HALF_CYC(8)) i_spfc_top (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .serial_clock_line, .chip_enable, .serial_data_in, .serial_data_out_oe, .port_out,
    .port_out_oe, .port_in_zero, .port_in_one, .high_speed_count_input,
    .low_speed_count_input);
  spfc_ctrl_model i_spfc_ctrl_model (.serial_clock_line, .chip_enable, .serial_data_in,
    .serial_data_out_oe);

  // ********
  // Clock, count sources, watchdog
  // ********
  initial begin
    aclk = 1'b0;
    forever #20 aclk = !aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (hs_half > 0 && cyc % hs_half == 0) high_speed_count_input <= !high_speed_count_input;
    if (ls_half > 0 && cyc % ls_half == 0) low_speed_count_input <= !low_speed_count_input;
    if (cyc == 6000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ********
  // Shared tasks
  // ********
  task automatic check(input string name, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check
  // Edges and gates may straddle by one count
  task automatic in_rng(input string name, input logic [31:0] v, input int lo, hi);
    check(name, 32'(v >= lo && v <= hi), 32'h1);
  endtask : in_rng
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    rs = bresp;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    rs = rresp;
  endtask : axi_rd
  task automatic send(input logic [35:0] w, output logic [27:0] r);
    i_spfc_ctrl_model.xfer(w, r);
    @(posedge aclk);
  endtask : send
  // Mode bits are {gate, function, source, timebase}
  task automatic measure(input logic [3:0] m, input int lo, hi);
    logic [27:0] r;
    logic [31:0] d;
    logic [1:0] rs;
    send({25'h0, m, 7'h00}, r);
    repeat (150) @(posedge aclk);
    axi_rd(`SPFC_ADDR_STATUS, d, rs);
    in_rng("status count", d[19:0], lo, hi);
    check("status pins", d[22:20], 3'b011);
    send({25'h0, m, 7'h00}, r);
    in_rng("serial count", r[27:8], lo, hi);
    check("serial flags", r[7:0], 8'h60);
  endtask : measure

  // ********
  // Scenarios
  // ********
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] rs;
    check("port level", port_out, 7'h7F);
    check("port enable", port_out_oe, 7'h06);
    axi_rd(`SPFC_ADDR_CTRL, d, rs);
    check("ctrl reset", d, 32'h1);
    axi_rd(8'h40, d, rs);
    check("bad read", rs, `SPFC_RESP_SLVERR);
    axi_wr(8'h40, 32'h0, rs);
    check("bad write", rs, `SPFC_RESP_SLVERR);
    axi_wr(`SPFC_ADDR_CTRL, 32'h0, rs);
    axi_rd(`SPFC_ADDR_CTRL, d, rs);
    check("ctrl off", d, 32'h0);
    axi_wr(`SPFC_ADDR_CTRL, 32'h1, rs);
    check("ctrl write", rs, `SPFC_RESP_OKAY);
    port_in_zero <= 1'b1;
    $display("test reset done");
  endtask : t_reset
  task automatic t_ports();
    logic [6:0] p [3] = '{7'h00, 7'h4A, 7'h35};
    logic [27:0] r;
    logic [31:0] d;
    logic [1:0] rs;
    for (int i = 0; i < 3; i++) begin
      send({4'hA, 25'h0, p[i]}, r);
      check("port level", port_out, 7'(~p[i]));
      check("port enable", port_out_oe, (p[i] & 7'h79) | 7'h06);
    end
    axi_rd(`SPFC_ADDR_WORD_LO, d, rs);
    check("word low", d, 32'h35);
    axi_rd(`SPFC_ADDR_WORD_HI, d, rs);
    check("word high", d, 32'hA);
    $display("test ports done");
  endtask : t_ports
  task automatic t_timebase();
    logic [27:0] r;
    int n = 0;
    logic last;
    send({25'h0, 4'b0001, 7'h00}, r);
    last = port_out[0];
    repeat (48) begin
      @(posedge aclk);
      if (port_out[0] !== last) n++;
      last = port_out[0];
    end
    in_rng("timebase edges", n, 5, 7);
    check("other ports", port_out[6:1], 6'h3F);
    $display("test timebase done");
  endtask : t_timebase
  task automatic t_high();
    hs_half = 1;
    measure(4'b0010, GS / 16 - 1, GS / 16 + 1);
    measure(4'b1010, GL / 16 - 1, GL / 16 + 1);
    $display("test high input done");
  endtask : t_high
  task automatic t_low_freq();
    ls_half = 2;
    measure(4'b0100, GS / 4 - 1, GS / 4 + 1);
    measure(4'b1100, GL / 4 - 1, GL / 4 + 1);
    $display("test low frequency done");
  endtask : t_low_freq
  task automatic t_period();
    ls_half = 5;
    measure(4'b0000, 9, 11);
    measure(4'b1000, 19, 21);
    $display("test period done");
  endtask : t_period

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_ports();
    t_timebase();
    t_high();
    t_low_freq();
    t_period();
    tally_and_finish();
  end
endmodule : tb
